//--- hdl/udci_regs.sv
// Purpose: control and completion interrupt registers of a usb descriptor dma
// Assumes: single clock mclk, synchronous active-high reset, plain register port
// Notes: raw receive flags are set by per-channel completion pulses
//
// Decided for this implementation: the address-and-strobe port and the register offsets.
`timescale 1ns/10ps
module udci_regs #(
  parameter int unsigned NCH = udci_pkg::NUM_CH
) (
  input wire logic mclk,
  input wire logic rst,
  input wire udci_pkg::udci_bus_type bus,
  output logic [31:0] rdata,
  input wire logic [NCH-1:0] rx_done_pulse,
  output logic rx_dma_on,
  output logic [NCH-1:0] tx_done_irq_enable_bits,
  output logic irq
);
  logic [NCH-1:0] tx_en_reg;
  logic [NCH-1:0] rx_en_reg;
  logic [NCH-1:0] rx_raw_reg;
  logic rx_on_reg;
  logic irq_reg;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic [NCH-1:0] masked;
  logic wr_tx_clr, wr_tx_set, wr_rx_set, wr_rx_clr, wr_raw_clr, wr_ctrl;

  assign wr_tx_clr = bus.wr && bus.addr == udci_pkg::OFF_TX_EN_CLR;
  assign wr_tx_set = bus.wr && bus.addr == udci_pkg::OFF_TX_EN_SET;
  assign wr_rx_set = bus.wr && bus.addr == udci_pkg::OFF_RX_EN_SET;
  assign wr_rx_clr = bus.wr && bus.addr == udci_pkg::OFF_RX_EN_CLR;
  assign wr_raw_clr = bus.wr && bus.addr == udci_pkg::OFF_RX_RAW_CLR;
  assign wr_ctrl = bus.wr && bus.addr == udci_pkg::OFF_RX_CTRL;
  assign masked = rx_raw_reg & rx_en_reg;

  // ****************************************
  // enable and flag state
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      always_ff @(posedge mclk) begin
        if (rst) begin
          tx_en_reg[g] <= udci_pkg::EN_RESET[g];
        end else if (wr_tx_clr && bus.wdata[g]) begin
          tx_en_reg[g] <= 1'b0;
        end else if (wr_tx_set && bus.wdata[g]) begin
          tx_en_reg[g] <= 1'b1;
        end
      end
      always_ff @(posedge mclk) begin
        if (rst) begin
          rx_en_reg[g] <= udci_pkg::EN_RESET[g];
        end else if (wr_rx_set && bus.wdata[g]) begin
          rx_en_reg[g] <= 1'b1;
        end else if (wr_rx_clr && bus.wdata[g]) begin
          rx_en_reg[g] <= 1'b0;
        end
      end
      // set wins over software clear
      always_ff @(posedge mclk) begin
        if (rst) begin
          rx_raw_reg[g] <= udci_pkg::RAW_RESET[g];
        end else if (rx_done_pulse[g]) begin
          rx_raw_reg[g] <= 1'b1;
        end else if (wr_raw_clr && bus.wdata[g]) begin
          rx_raw_reg[g] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge mclk) begin
    if (rst) begin
      rx_on_reg <= udci_pkg::RX_ON_RESET;
    end else if (wr_ctrl) begin
      rx_on_reg <= bus.wdata[udci_pkg::RX_ON_BIT];
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(((rx_raw_reg | rx_done_pulse) & ~({NCH{wr_raw_clr}} & bus.wdata[NCH-1:0] & ~rx_done_pulse))
                   & (rx_en_reg | ({NCH{wr_rx_set}} & bus.wdata[NCH-1:0]))
                   & ~({NCH{wr_rx_clr && !wr_rx_set}} & bus.wdata[NCH-1:0]));
    end
  end

  // ****************************************
  // read port
  // ****************************************
  always_comb begin
    rdata_next = 32'h0000_0000;
    if (bus.addr == udci_pkg::OFF_TX_EN) begin
      rdata_next[NCH-1:0] = tx_en_reg;
    end else if (bus.addr == udci_pkg::OFF_RX_CTRL) begin
      rdata_next[udci_pkg::RX_ON_BIT] = rx_on_reg;
    end else if (bus.addr == udci_pkg::OFF_RX_MASKED) begin
      rdata_next[NCH-1:0] = masked;
    end else if (bus.addr == udci_pkg::OFF_RX_RAW) begin
      rdata_next[NCH-1:0] = rx_raw_reg;
    end else if (bus.addr == udci_pkg::OFF_RX_EN) begin
      rdata_next[NCH-1:0] = rx_en_reg;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      rdata_reg <= 32'h0000_0000;
    end else if (bus.rd) begin
      rdata_reg <= rdata_next;
    end else begin
      rdata_reg <= 32'h0000_0000;
    end
  end

  assign rdata = rdata_reg;
  assign rx_dma_on = rx_on_reg;
  assign tx_done_irq_enable_bits = tx_en_reg;
  assign irq = irq_reg;

  // ****************************************
  // checks
  // ****************************************
  sequence s_tx_clr;
    wr_tx_clr && bus.wdata[0];
  endsequence
  a_tx_clear_bit: assert property (@(posedge mclk) disable iff (rst) s_tx_clr |=> !tx_en_reg[0])
    else $error("tx enable bit 0 not cleared");
  a_rx_on_write: assert property (@(posedge mclk) disable iff (rst)
    wr_ctrl |=> rx_dma_on == $past(bus.wdata[0]))
    else $error("rx dma enable did not follow write");
  a_raw_set: assert property (@(posedge mclk) disable iff (rst) rx_done_pulse[1] |=> rx_raw_reg[1])
    else $error("raw flag not set on completion");
  a_masked_read: assert property (@(posedge mclk) disable iff (rst)
    bus.rd && bus.addr == udci_pkg::OFF_RX_MASKED |=> rdata[NCH-1:0] == $past(rx_raw_reg & rx_en_reg))
    else $error("masked status read wrong");
  a_rx_en_set: assert property (@(posedge mclk) disable iff (rst)
    wr_rx_set && bus.wdata[2] |=> rx_en_reg[2])
    else $error("rx enable not set");
  a_rx_en_clr: assert property (@(posedge mclk) disable iff (rst)
    wr_rx_clr && bus.wdata[3] && !wr_rx_set |=> !rx_en_reg[3])
    else $error("rx enable not cleared");
  a_reserved_zero: assert property (@(posedge mclk) disable iff (rst) rdata[31:NCH] == '0)
    else $error("reserved bits nonzero");
  a_irq_level: assert property (@(posedge mclk) disable iff (rst)
    ##1 irq == |(rx_raw_reg & rx_en_reg))
    else $error("irq mismatch with masked status");

  // ****************************************
  // read port and rx dma enable hold checks
  // ****************************************
  // a read of the raw flags must return the state of the cycle it was taken in
  sequence s_raw_read;
    bus.rd && bus.addr == udci_pkg::OFF_RX_RAW;
  endsequence
  sequence s_ctrl_read;
    bus.rd && bus.addr == udci_pkg::OFF_RX_CTRL;
  endsequence
  a_raw_read: assert property (@(posedge mclk) disable iff (rst)
    s_raw_read |=> rdata[NCH-1:0] == $past(rx_raw_reg))
    else $error("raw status read wrong");
  a_ctrl_read: assert property (@(posedge mclk) disable iff (rst)
    s_ctrl_read |=> rdata == {31'h0000_0000, $past(rx_on_reg)})
    else $error("rx control read wrong");
  a_rdata_idle: assert property (@(posedge mclk) disable iff (rst)
    !bus.rd |=> rdata == 32'h0000_0000)
    else $error("read data not zero outside a read");
  a_rx_on_hold: assert property (@(posedge mclk) disable iff (rst)
    !wr_ctrl |=> $stable(rx_dma_on))
    else $error("rx dma enable changed without a write");

  // ****************************************
  // per-channel checks
  // ****************************************
  genvar h;
  generate
    for (h = 0; h < NCH; h++) begin : g_chk
      a_tx_clr_each: assert property (@(posedge mclk) disable iff (rst)
        wr_tx_clr && bus.wdata[h] |=> !tx_done_irq_enable_bits[h])
        else $error("tx enable bit not cleared");
      // zero bits of a clear write must leave the enable alone
      a_tx_zero_keep: assert property (@(posedge mclk) disable iff (rst)
        wr_tx_clr && !bus.wdata[h] |=> $stable(tx_done_irq_enable_bits[h]))
        else $error("tx enable bit changed by a zero write");
      // a completion in the same cycle as a software clear must not be lost
      a_raw_set_wins: assert property (@(posedge mclk) disable iff (rst)
        rx_done_pulse[h] && wr_raw_clr && bus.wdata[h] |=> rx_raw_reg[h])
        else $error("completion lost against clear");
      a_raw_clear: assert property (@(posedge mclk) disable iff (rst)
        wr_raw_clr && bus.wdata[h] && !rx_done_pulse[h] |=> !rx_raw_reg[h])
        else $error("raw flag not cleared");
      a_raw_keep: assert property (@(posedge mclk) disable iff (rst)
        !rx_done_pulse[h] && !(wr_raw_clr && bus.wdata[h]) |=> $stable(rx_raw_reg[h]))
        else $error("raw flag changed with no cause");
      a_rx_en_keep: assert property (@(posedge mclk) disable iff (rst)
        !(wr_rx_set && bus.wdata[h]) && !(wr_rx_clr && bus.wdata[h]) |=> $stable(rx_en_reg[h]))
        else $error("rx enable changed with no write");
      a_masked_bit: assert property (@(posedge mclk) disable iff (rst)
        masked[h] == (rx_raw_reg[h] && rx_en_reg[h]))
        else $error("masked status bit wrong");
    end
  endgenerate
endmodule : udci_regs

//--- shared/udci_pkg.sv
// Purpose: constants and types shared by the dma completion interrupt register block
// Assumes: 32-bit register port, word offsets are byte addresses
// Notes: all fields reset to zero
package udci_pkg;
  localparam int unsigned NUM_CH = 4;
  localparam logic [7:0] OFF_TX_EN = 8'h00;
  localparam logic [7:0] OFF_TX_EN_CLR = 8'h04;
  localparam logic [7:0] OFF_RX_CTRL = 8'h08;
  localparam logic [7:0] OFF_RX_MASKED = 8'h0c;
  localparam logic [7:0] OFF_RX_RAW = 8'h10;
  localparam logic [7:0] OFF_RX_EN = 8'h14;
  localparam logic [7:0] OFF_RX_EN_SET = 8'h18;
  localparam logic [7:0] OFF_RX_EN_CLR = 8'h1c;
  localparam logic [7:0] OFF_RX_RAW_CLR = 8'h20;
  localparam logic [7:0] OFF_TX_EN_SET = 8'h24;
  localparam int unsigned RX_ON_BIT = 0;
  localparam logic [3:0] EN_RESET = 4'h0;
  localparam logic [3:0] RAW_RESET = 4'h0;
  localparam logic RX_ON_RESET = 1'b0;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } udci_bus_type;
endpackage : udci_pkg

//--- verification/udci_tb.sv
// Purpose: self-checking bench for the dma completion interrupt registers
// Assumes: read data stand in the cycle after the read strobe
// Notes: no random stimulus; irq lags its cause by one cycle
`timescale 1ns/10ps
module testbench;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  udci_pkg::udci_bus_type bus = '0;
  logic [31:0] rdata;
  logic [3:0] rx_done_pulse = 4'h0;
  logic rx_dma_on;
  logic [3:0] tx_done_irq_enable_bits;
  logic irq;
  int n_errors = 0;
  int samples_checked = 0;
  always #4 mclk = ~mclk;
  udci_regs udci_regs_inst (.mclk(mclk), .rst(rst), .bus(bus), .rdata(rdata), .rx_done_pulse(rx_done_pulse),
    .rx_dma_on(rx_dma_on), .tx_done_irq_enable_bits(tx_done_irq_enable_bits), .irq(irq));
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    bus <= {a, d, 1'b1, 1'b0};
    @(posedge mclk);
    bus.wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge mclk);
    bus <= {a, 32'h0, 1'b0, 1'b1};
    @(posedge mclk);
    bus.rd <= 1'b0;
    #1 chk($sformatf("read %h", a), rdata, exp);
  endtask : rd
  task automatic end_of_test();
    $display("mismatches %0d, checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_of_test
  // ********************************
  // tests
  // ********************************
  initial begin
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    rd(8'h08, 32'h0);
    rd(8'h10, 32'h0);
    rd(8'h0c, 32'h0);
    wr(8'h08, 32'hffffffff);
    rd(8'h08, 32'h1);
    chk("rx_dma_on", {31'h0, rx_dma_on}, 32'h1);
    wr(8'h08, 32'hfffffffe);
    rd(8'h08, 32'h0);
    chk("rx_dma_on", {31'h0, rx_dma_on}, 32'h0);
    @(posedge mclk);
    rx_done_pulse <= 4'ha;
    @(posedge mclk);
    rx_done_pulse <= 4'h0;
    rd(8'h10, 32'ha);
    chk("irq", {31'h0, irq}, 32'h0);
    wr(8'h18, 32'hfffffff5);
    rd(8'h14, 32'h5);
    rd(8'h0c, 32'h0);
    wr(8'h18, 32'h2);
    rd(8'h0c, 32'h2);
    chk("irq", {31'h0, irq}, 32'h1);
    wr(8'h1c, 32'h2);
    rd(8'h14, 32'h5);
    rd(8'h0c, 32'h0);
    chk("irq", {31'h0, irq}, 32'h0);
    wr(8'h10, 32'hf);
    rd(8'h10, 32'ha);
    wr(8'h20, 32'ha);
    rd(8'h10, 32'h0);
    // completion on channel 0 in the same cycle as its clear: the completion wins
    @(posedge mclk);
    bus <= {8'h20, 32'h1, 1'b1, 1'b0};
    rx_done_pulse <= 4'h1;
    @(posedge mclk);
    bus.wr <= 1'b0;
    rx_done_pulse <= 4'h0;
    rd(8'h10, 32'h1);
    rd(8'h0c, 32'h1);
    chk("irq", {31'h0, irq}, 32'h1);
    wr(8'h20, 32'h1);
    rd(8'h10, 32'h0);
    chk("irq", {31'h0, irq}, 32'h0);
    wr(8'h24, 32'hf);
    wr(8'h04, 32'h5);
    rd(8'h00, 32'ha);
    chk("tx enables", {28'h0, tx_done_irq_enable_bits}, 32'ha);
    wr(8'h04, 32'h0);
    rd(8'h00, 32'ha);
    rd(8'h04, 32'h0);
    rd(8'h80, 32'h0);
    end_of_test();
  end
  // watchdog: the tests need well under a thousand cycles
  initial begin
    #20000;
    n_errors++;
    end_of_test();
  end
endmodule : testbench
